// [cfg_line_pkg.sv]
// ****************************************************************
// shared constants and types
// ****************************************************************
package cfg_line_pkg;

  // characters the line grammar cares about
  localparam logic [7:0] CHR_SEMI  = 8'h3B;
  localparam logic [7:0] CHR_COLON = 8'h3A;
  localparam logic [7:0] CHR_EQ    = 8'h3D;
  localparam logic [7:0] CHR_DOT   = 8'h2E;
  localparam logic [7:0] CHR_BAR   = 8'h7C;
  localparam logic [7:0] CHR_AMP   = 8'h26;
  localparam logic [7:0] CHR_LF    = 8'h0A;
  localparam logic [7:0] CHR_CR    = 8'h0D;
  localparam logic [7:0] CHR_SPACE = 8'h20;
  localparam logic [7:0] CHR_X     = 8'h78;

  // field widths in characters, character count saturation and bit-number limit
  localparam logic [2:0] IDX_CHARS = 3'h4;
  localparam logic [2:0] SUB_CHARS = 3'h2;
  localparam logic [2:0] BIT_CHARS = 3'h2;
  localparam logic [2:0] CNT_SAT   = 3'h7;
  localparam logic [6:0] BIT_LIMIT = 7'h20;

  // program-control object
  localparam logic [15:0] PROG_CTRL_INDEX = 16'h2300;
  localparam logic [7:0]  PROG_CTRL_SUB   = 8'h00;
  localparam logic [31:0] PROG_RUN_VALUE  = 32'h0000_0001;

  typedef enum logic [1:0] {
    OP_SET = 2'h0,
    OP_OR  = 2'h1,
    OP_AND = 2'h2,
    OP_BIT = 2'h3
  } od_op_t;

  typedef struct packed {
    logic [15:0] index;
    logic [7:0]  sub;
  } od_addr_t;

  typedef struct packed {
    od_addr_t    addr;
    logic [31:0] data;
  } od_wr_t;

  // ****************************************************************
  // arithmetic helpers
  // ****************************************************************
  function automatic logic [31:0] dec_acc(input logic [31:0] acc, input logic [3:0] d);
    logic [35:0] wide;
    wide = {4'h0, acc} * 36'd10 + {32'h0, d};
    return wide[31:0];
  endfunction

  function automatic logic [31:0] hex_acc(input logic [31:0] acc, input logic [3:0] d);
    return {acc[27:0], d};
  endfunction

  // read-modify-write result for the OR, AND and single-bit forms
  function automatic logic [31:0] apply_op(input logic [31:0] old, input od_op_t op,
                                           input logic [4:0] bitn, input logic [31:0] v);
    logic [31:0] r;
    r = old;
    case (op)
      OP_OR:   r = old | v;
      OP_AND:  r = old & v;
      OP_BIT:  r[bitn] = v[0];
      default: r = v;
    endcase
    return r;
  endfunction

endpackage

// ****************************************************************
// character classifier
// ****************************************************************
`timescale 1ns/10ps
module cfg_char_class (
  input  wire logic [7:0] chr_i,
  output wire logic       is_hex_o,
  output wire logic       is_dec_o,
  output wire logic [3:0] nibble_o
);
  wire logic is_dig = (chr_i >= 8'h30) && (chr_i <= 8'h39);
  wire logic is_up  = (chr_i >= 8'h41) && (chr_i <= 8'h46);
  wire logic is_low = (chr_i >= 8'h61) && (chr_i <= 8'h66);
  wire logic [7:0] dig_off = chr_i - 8'h30;
  wire logic [7:0] up_off  = chr_i - 8'h37;
  wire logic [7:0] low_off = chr_i - 8'h57;

  // both letter cases accepted for hex digits
  assign is_dec_o = is_dig;
  assign is_hex_o = is_dig || is_up || is_low;
  assign nibble_o = is_dig ? dig_off[3:0] : (is_up ? up_off[3:0] : low_off[3:0]);
endmodule

// [cfg_line_interp.sv]
`timescale 1ns/10ps
module cfg_line_interp
  import cfg_line_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  output wire logic        restore_req_o,
  input  wire logic        restore_done_i,
  input  wire logic [7:0]  chr_i,
  input  wire logic        chr_valid_i,
  output wire logic        chr_ready_o,
  input  wire logic        file_end_i,
  output wire logic        od_rd_req_o,
  output wire od_addr_t    od_rd_addr_o,
  input  wire logic        od_rd_valid_i,
  input  wire logic [31:0] od_rdata_i,
  output wire logic        od_wr_valid_o,
  output wire od_wr_t      od_wr_o,
  input  wire logic        od_wr_ready_i,
  output wire logic        config_done_o,
  output wire logic        prog_start_o
);

  // ****************************************************************
  // state and storage
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_RESTORE = 4'h0,
    ST_IDX     = 4'h1,
    ST_SUB     = 4'h3,
    ST_OP      = 4'h2,
    ST_VAL     = 4'h6,
    ST_READ    = 4'h7,
    ST_WRITE   = 4'h5,
    ST_BITNUM  = 4'h4,
    ST_SKIP    = 4'hC,
    ST_FINISH  = 4'hD,
    ST_DONE    = 4'hF
  } state_t;

  state_t      state_reg, state_next;
  logic [15:0] idx_reg, idx_next;
  logic [7:0]  sub_reg, sub_next;
  logic [6:0]  bit_reg, bit_next;
  od_op_t      op_reg, op_next;
  logic [31:0] val_reg, val_next;
  logic [31:0] wr_data_reg, wr_data_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic        hex_mode_reg, hex_mode_next;
  logic        eof_reg, eof_next;
  logic        run_reg, run_next;
  logic        start_reg, start_next;
  logic        restored_reg;

  // ****************************************************************
  // character decode
  // ****************************************************************
  wire logic       is_hex;
  wire logic       is_dec;
  wire logic [3:0] nib;

  cfg_char_class u_class (
    .chr_i    (chr_i),
    .is_hex_o (is_hex),
    .is_dec_o (is_dec),
    .nibble_o (nib)
  );

  wire logic       parsing  = (state_reg == ST_IDX) || (state_reg == ST_SUB) || (state_reg == ST_OP) ||
                              (state_reg == ST_VAL) || (state_reg == ST_BITNUM) || (state_reg == ST_SKIP);
  wire logic       take     = chr_valid_i && parsing;
  wire logic       at_eof   = file_end_i && !chr_valid_i && parsing;
  wire logic       is_lf    = (chr_i == CHR_LF);
  wire logic [2:0] cnt_inc  = (cnt_reg == CNT_SAT) ? CNT_SAT : cnt_reg + 3'h1;
  // bit form accepts only 0 or 1; any value needs at least one digit
  wire logic       val_ok   = (cnt_reg != 3'h0) && ((op_reg != OP_BIT) || (val_reg <= 32'h1));
  wire logic       val_digit = hex_mode_reg ? is_hex : is_dec;
  wire logic       to_hex   = (chr_i == CHR_X) && !hex_mode_reg && (cnt_reg == 3'h1) && (val_reg == 32'h0);
  wire logic       prog_hit = (idx_reg == PROG_CTRL_INDEX) && (sub_reg == PROG_CTRL_SUB);

  // handshakes are combinational, data comes from flip-flops
  assign restore_req_o = (state_reg == ST_RESTORE);
  assign chr_ready_o   = parsing;
  assign od_rd_req_o   = (state_reg == ST_READ);
  assign od_rd_addr_o  = '{index: idx_reg, sub: sub_reg};
  assign od_wr_valid_o = (state_reg == ST_WRITE);
  assign od_wr_o       = '{addr: '{index: idx_reg, sub: sub_reg}, data: wr_data_reg};
  assign config_done_o = (state_reg == ST_DONE);
  assign prog_start_o  = start_reg;

  // ****************************************************************
  // line parser and sequencer
  // ****************************************************************
  always_comb begin
    state_next    = state_reg;
    idx_next      = idx_reg;
    sub_next      = sub_reg;
    bit_next      = bit_reg;
    op_next       = op_reg;
    val_next      = val_reg;
    wr_data_next  = wr_data_reg;
    cnt_next      = cnt_reg;
    hex_mode_next = hex_mode_reg;
    eof_next      = eof_reg;
    run_next      = run_reg;
    start_next    = 1'b0;
    case (state_reg)
      ST_RESTORE: begin
        if (restore_done_i) begin
          state_next = ST_IDX;
        end
      end
      ST_IDX: begin
        if (at_eof) begin
          state_next = ST_FINISH;
        end else if (take) begin
          if (cnt_reg == 3'h0 && is_lf) begin
            state_next = ST_IDX;
          end else if (cnt_reg == 3'h0 && chr_i == CHR_SEMI) begin
            state_next = ST_SKIP;
          end else if (cnt_reg == IDX_CHARS && chr_i == CHR_COLON) begin
            state_next = ST_SUB;
            cnt_next   = 3'h0;
          end else if (cnt_reg != IDX_CHARS && is_hex) begin
            idx_next = {idx_reg[11:0], nib};
            cnt_next = cnt_inc;
          end else begin
            state_next = is_lf ? ST_IDX : ST_SKIP;
            cnt_next   = 3'h0;
          end
        end
      end
      ST_SUB: begin
        if (at_eof) begin
          state_next = ST_FINISH;
        end else if (take) begin
          if (cnt_reg != SUB_CHARS && is_hex) begin
            sub_next = {sub_reg[3:0], nib};
            cnt_next = cnt_inc;
          end else if (cnt_reg == SUB_CHARS && chr_i == CHR_DOT) begin
            state_next = ST_BITNUM;
            cnt_next   = 3'h0;
            op_next    = OP_BIT;
          end else if (cnt_reg == SUB_CHARS && chr_i == CHR_EQ) begin
            state_next = ST_VAL;
            cnt_next   = 3'h0;
            op_next    = OP_SET;
          end else if (cnt_reg == SUB_CHARS && (chr_i == CHR_BAR || chr_i == CHR_AMP)) begin
            state_next = ST_OP;
            op_next    = (chr_i == CHR_BAR) ? OP_OR : OP_AND;
          end else begin
            state_next = is_lf ? ST_IDX : ST_SKIP;
            cnt_next   = 3'h0;
          end
        end
      end
      ST_BITNUM: begin
        if (at_eof) begin
          state_next = ST_FINISH;
        end else if (take) begin
          if (cnt_reg != BIT_CHARS && is_dec) begin
            bit_next = 7'(bit_reg * 7'd10 + {3'h0, nib});
            cnt_next = cnt_inc;
          end else if (cnt_reg == BIT_CHARS && chr_i == CHR_EQ && bit_reg < BIT_LIMIT) begin
            state_next = ST_VAL;
            cnt_next   = 3'h0;
          end else begin
            state_next = is_lf ? ST_IDX : ST_SKIP;
            cnt_next   = 3'h0;
          end
        end
      end
      ST_OP: begin
        if (at_eof) begin
          state_next = ST_FINISH;
        end else if (take) begin
          state_next = (chr_i == CHR_EQ) ? ST_VAL : (is_lf ? ST_IDX : ST_SKIP);
          cnt_next   = 3'h0;
        end
      end
      ST_VAL: begin
        if ((at_eof || (take && is_lf)) && val_ok) begin
          // set form needs no read; others read the object first
          state_next   = (op_reg == OP_SET) ? ST_WRITE : ST_READ;
          wr_data_next = val_reg;
          eof_next     = at_eof;
        end else if (at_eof) begin
          state_next = ST_FINISH;
        end else if (take) begin
          if (is_lf) begin
            state_next = ST_IDX;
            cnt_next   = 3'h0;
          end else if (chr_i == CHR_CR) begin
            state_next = ST_VAL; // tolerate cr-lf line ends
          end else if (to_hex) begin
            hex_mode_next = 1'b1;
            cnt_next      = 3'h0;
          end else if (val_digit) begin
            val_next = hex_mode_reg ? hex_acc(val_reg, nib) : dec_acc(val_reg, nib);
            cnt_next = cnt_inc;
          end else begin
            state_next = ST_SKIP;
            cnt_next   = 3'h0;
          end
        end
      end
      ST_READ: begin
        if (od_rd_valid_i) begin
          state_next   = ST_WRITE;
          wr_data_next = apply_op(od_rdata_i, op_reg, bit_reg[4:0], val_reg);
        end
      end
      ST_WRITE: begin
        // one write completes before the next line is read
        if (od_wr_ready_i) begin
          state_next = eof_reg ? ST_FINISH : ST_IDX;
          cnt_next   = 3'h0;
          if (prog_hit) begin
            run_next = (wr_data_reg == PROG_RUN_VALUE);
          end
        end
      end
      ST_SKIP: begin
        if (at_eof) begin
          state_next = ST_FINISH;
        end else if (take && is_lf) begin
          state_next = ST_IDX;
          cnt_next   = 3'h0;
        end
      end
      ST_FINISH: begin
        state_next = ST_DONE;
        start_next = run_reg;
      end
      default: begin
        state_next = ST_DONE;
      end
    endcase
    // every new line starts with clean fields
    if (state_next == ST_IDX && state_reg != ST_IDX) begin
      idx_next      = 16'h0;
      sub_next      = 8'h0;
      bit_next      = 7'h0;
      val_next      = 32'h0;
      hex_mode_next = 1'b0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg    <= ST_RESTORE;
      idx_reg      <= 16'h0;
      sub_reg      <= 8'h0;
      bit_reg      <= 7'h0;
      op_reg       <= OP_SET;
      val_reg      <= 32'h0;
      wr_data_reg  <= 32'h0;
      cnt_reg      <= 3'h0;
      hex_mode_reg <= 1'b0;
      eof_reg      <= 1'b0;
      run_reg      <= 1'b0;
      start_reg    <= 1'b0;
    end else begin
      state_reg    <= state_next;
      idx_reg      <= idx_next;
      sub_reg      <= sub_next;
      bit_reg      <= bit_next;
      op_reg       <= op_next;
      val_reg      <= val_next;
      wr_data_reg  <= wr_data_next;
      cnt_reg      <= cnt_next;
      hex_mode_reg <= hex_mode_next;
      eof_reg      <= eof_next;
      run_reg      <= run_next;
      start_reg    <= start_next;
    end
  end

  // helper for the ordering check
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      restored_reg <= 1'b0;
    end else if (state_reg == ST_RESTORE && restore_done_i) begin
      restored_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence seq_line_start(logic [7:0] c);
    state_reg == ST_IDX && cnt_reg == 3'h0 && chr_valid_i && chr_i == c;
  endsequence

  sequence seq_set_commit;
    state_reg == ST_VAL && take && is_lf && val_ok && op_reg == OP_SET;
  endsequence

  a_comment_skip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    seq_line_start(CHR_SEMI) |=> state_reg == ST_SKIP && !od_wr_valid_o)
    else $error("comment line not skipped");

  a_leading_blank: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    seq_line_start(CHR_SPACE) |=> state_reg == ST_SKIP)
    else $error("leading blank accepted");

  a_index_width: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_reg == ST_IDX && cnt_reg != IDX_CHARS && take && chr_i == CHR_COLON |=> state_reg == ST_SKIP)
    else $error("short index accepted");

  a_sub_width: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_reg == ST_SUB && cnt_reg != SUB_CHARS && take && chr_i == CHR_EQ |=> state_reg == ST_SKIP)
    else $error("short subindex accepted");

  a_restore_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !restored_reg |-> !od_wr_valid_o && !chr_ready_o)
    else $error("file used before restore");

  a_set_value: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    seq_set_commit |=> od_wr_valid_o && od_wr_o.data == $past(val_reg))
    else $error("set value altered");

  a_rmw_value: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_reg == ST_READ && od_rd_valid_i |=> od_wr_valid_o &&
      od_wr_o.data == apply_op($past(od_rdata_i), op_reg, bit_reg[4:0], val_reg))
    else $error("modify result wrong");

  a_write_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    od_wr_valid_o && !od_wr_ready_i |=> od_wr_valid_o && $stable(od_wr_o))
    else $error("write dropped before accept");

  a_prog_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_reg == ST_FINISH && run_reg |=> prog_start_o ##1 !prog_start_o)
    else $error("program start missing");

  a_start_late: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    prog_start_o |-> config_done_o && $past(state_reg == ST_FINISH))
    else $error("program started early");

endmodule

// [cfg_od_store.sv]
`timescale 1ns/10ps
// ****
// object dictionary store seen from the interpreter
// ****
module cfg_od_store
  import cfg_line_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     sys_rst_i,
  input  wire logic     restore_req_i,
  output logic          restore_done_o,
  input  wire logic     od_rd_req_i,
  input  wire od_addr_t od_rd_addr_i,
  output logic          od_rd_valid_o,
  output logic [31:0]   od_rdata_o,
  input  wire logic     od_wr_valid_i,
  input  wire od_wr_t   od_wr_i,
  output logic          od_wr_ready_o
);
  logic [31:0] mem [logic [23:0]];
  od_wr_t      wr_log [$];
  int          lat = 0;
  int          wait_cnt = 0;
  bit          restored = 1'b0;

  // one answer per request, once lat cycles have passed since reset or the last answer; stale read data is flipped every
  // cycle so a late sample cannot pass for a fresh one
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      restore_done_o <= 1'b0;
      od_rd_valid_o  <= 1'b0;
      od_wr_ready_o  <= 1'b0;
      od_rdata_o     <= 32'h0;
      wait_cnt       <= 0;
      restored       <= 1'b0;
    end else if (restore_done_o || od_rd_valid_o || od_wr_ready_o) begin
      if (restore_done_o && restore_req_i) begin
        mem.delete();
        mem[24'h320200] = 32'h0000_0040;
        mem[24'h604000] = 32'h0000_00F0;
        restored <= 1'b1;
      end
      if (od_wr_ready_o && od_wr_valid_i) begin
        wr_log.push_back(od_wr_i);
        mem[od_wr_i.addr] = od_wr_i.data;
      end
      restore_done_o <= 1'b0;
      od_rd_valid_o  <= 1'b0;
      od_wr_ready_o  <= 1'b0;
      od_rdata_o     <= ~od_rdata_o;
      wait_cnt       <= 0;
    end else if ((restore_req_i || od_rd_req_i || od_wr_valid_i) && wait_cnt >= lat) begin
      restore_done_o <= restore_req_i && !restored;
      od_rd_valid_o  <= od_rd_req_i;
      od_wr_ready_o  <= od_wr_valid_i;
      od_rdata_o     <= mem.exists(od_rd_addr_i) ? mem[od_rd_addr_i] : 32'h0;
    end else begin
      wait_cnt       <= wait_cnt + 1;
      od_rdata_o     <= ~od_rdata_o;
    end
  end
endmodule

// [cfg_line_interp_tb.sv]
`timescale 1ns/10ps
module cfg_line_interp_tb;
  import cfg_line_pkg::*;
  typedef struct {
    string       line;
    bit          wr;
    logic [23:0] addr;
    logic [31:0] data;
  } row_t;

  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  chr_i = 8'h00;
  logic        chr_valid_i = 1'b0;
  logic        file_end_i = 1'b0;
  logic        restore_req_o;
  logic        restore_done_i;
  logic        chr_ready_o;
  logic        od_rd_req_o;
  od_addr_t    od_rd_addr_o;
  logic        od_rd_valid_i;
  logic [31:0] od_rdata_i;
  logic        od_wr_valid_o;
  od_wr_t      od_wr_o;
  logic        od_wr_ready_i;
  logic        config_done_o;
  logic        prog_start_o;
  logic        rdy_s = 1'b0;
  logic        done_s = 1'b0;
  int          fail_count = 0;
  int          compares = 0;
  int          starts = 0;
  row_t        rows [19];

  always #12.5 clk_i = ~clk_i;

  cfg_line_interp cfg_line_interp_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .restore_req_o(restore_req_o),
    .restore_done_i(restore_done_i), .chr_i(chr_i), .chr_valid_i(chr_valid_i), .chr_ready_o(chr_ready_o),
    .file_end_i(file_end_i), .od_rd_req_o(od_rd_req_o), .od_rd_addr_o(od_rd_addr_o),
    .od_rd_valid_i(od_rd_valid_i), .od_rdata_i(od_rdata_i), .od_wr_valid_o(od_wr_valid_o),
    .od_wr_o(od_wr_o), .od_wr_ready_i(od_wr_ready_i), .config_done_o(config_done_o),
    .prog_start_o(prog_start_o));

  cfg_od_store cfg_od_store_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .restore_req_i(restore_req_o),
    .restore_done_o(restore_done_i), .od_rd_req_i(od_rd_req_o), .od_rd_addr_i(od_rd_addr_o),
    .od_rd_valid_o(od_rd_valid_i), .od_rdata_o(od_rdata_i), .od_wr_valid_i(od_wr_valid_o),
    .od_wr_i(od_wr_o), .od_wr_ready_o(od_wr_ready_i));

  // ****
  // helpers
  // ****
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // mid-cycle samples, so no edge-time race with the design's state update
  always @(negedge clk_i) begin
    rdy_s = chr_ready_o;
    done_s = config_done_o;
    if (!sys_rst_i && restore_req_o === 1'b1 && (chr_ready_o === 1'b1 || od_wr_valid_o === 1'b1)) begin
      check("work before restore", 32'h0, 32'h1);
    end
    if (prog_start_o === 1'b1) begin
      starts++;
      if (done_s !== 1'b1) begin
        check("start before done", 32'h0, 32'h1);
      end
    end
  end

  task automatic wait_for(input bit for_done);
    int n;
    n = 0;
    @(posedge clk_i);
    while ((for_done ? done_s : rdy_s) !== 1'b1) begin
      if (n == 400) begin
        check("handshake wait", 32'h1, 32'h0);
        final_report();
      end
      n++;
      @(posedge clk_i);
    end
  endtask

  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      chr_i <= 8'(s[i]);
      chr_valid_i <= 1'b1;
      wait_for(1'b0);
    end
  endtask

  task automatic idle();
    chr_valid_i <= 1'b0;
    wait_for(1'b0);
  endtask

  task automatic finish_file();
    chr_valid_i <= 1'b0;
    file_end_i <= 1'b1;
    wait_for(1'b1);
    repeat (3) @(posedge clk_i);
  endtask

  task automatic do_reset();
    sys_rst_i <= 1'b1;
    chr_valid_i <= 1'b0;
    file_end_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    check("restore request", 32'h1, {31'h0, restore_req_o});
    check("ready in reset", 32'h0, {31'h0, chr_ready_o});
    check("done in reset", 32'h0, {31'h0, config_done_o});
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    // well formed rows carry no blanks
    rows = '{
      '{";2300:00=1", 1'b0, 24'h0, 32'h0},
      '{"203B:01=600", 1'b1, 24'h203B01, 32'h0000_0258},
      '{"3202:00|=0x08", 1'b1, 24'h320200, 32'h0000_0048},
      '{"3202:00.03=0", 1'b1, 24'h320200, 32'h0000_0040},
      '{"3202:00.00=1", 1'b1, 24'h320200, 32'h0000_0041},
      '{"3202:00&=0x0F", 1'b1, 24'h320200, 32'h0000_0001},
      '{"6040:00=0xFFFFFFFF", 1'b1, 24'h604000, 32'hFFFF_FFFF},
      '{"6040:0=6", 1'b0, 24'h0, 32'h0},
      '{"6040=6", 1'b0, 24'h0, 32'h0},
      '{"6040:00 =5", 1'b0, 24'h0, 32'h0},
      '{"6040:00= 5", 1'b0, 24'h0, 32'h0},
      '{" 6040:00=5", 1'b0, 24'h0, 32'h0},
      '{"60400:00=5", 1'b0, 24'h0, 32'h0},
      '{"604:00=5", 1'b0, 24'h0, 32'h0},
      '{"6040:00=5", 1'b1, 24'h604000, 32'h0000_0005},
      '{"3202:00.31=1", 1'b1, 24'h320200, 32'h8000_0001},
      '{"6040:00.32=1", 1'b0, 24'h0, 32'h0},
      '{"6040:00&=0xaB", 1'b1, 24'h604000, 32'h0000_0001},
      '{"", 1'b0, 24'h0, 32'h0}};
    cfg_od_store_i.lat = 3;
    do_reset();
    idle();
    foreach (rows[k]) begin
      cfg_od_store_i.lat = k % 3;
      cfg_od_store_i.wr_log.delete();
      send({rows[k].line, "\n"});
      idle();
      check(rows[k].line, {31'h0, rows[k].wr}, 32'(cfg_od_store_i.wr_log.size()));
      if (rows[k].wr && cfg_od_store_i.wr_log.size() == 1) begin
        check(rows[k].line, {8'h00, rows[k].addr}, {8'h00, cfg_od_store_i.wr_log[0].addr});
        check(rows[k].line, rows[k].data, cfg_od_store_i.wr_log[0].data);
      end
    end
    // last line without a line end, committed at end of file
    cfg_od_store_i.wr_log.delete();
    send("2300:00=1");
    finish_file();
    check("last line writes", 32'h1, 32'(cfg_od_store_i.wr_log.size()));
    check("start pulses", 32'h1, 32'(starts));
    // reset in mid-line, then a later line cancels the start request
    starts = 0;
    cfg_od_store_i.lat = 0;
    do_reset();
    idle();
    send("2300:00");
    do_reset();
    idle();
    cfg_od_store_i.wr_log.delete();
    send("2300:00=1\n2300:00=0\n");
    finish_file();
    check("writes after reset", 32'h2, 32'(cfg_od_store_i.wr_log.size()));
    check("start pulses", 32'h0, 32'(starts));
    final_report();
  end
endmodule
